//--- hw/bridge_cfg_pkg.sv
// Function
// - Channel A clock band byte, read/write
// - Channel B clock band byte, same encoding
// - Code N means 5N up to 5N+5 MHz
// - Enable invert bit flips output data-enable
// - Hsync invert bit drives hsync low in sync
// - Vsync invert bit drives vsync low in sync
// - Link bit 0, mode 00/01: dual link
// - Link bit 0, mode 10: two single links
// - Link bit 1: single link, only A enabled
// - Channel A depth bit: 18 or 24 bpp
// - Channel B depth bit: 18 or 24 bpp
// - Channel A format bit picks lane4 MSBs/LSBs
// - Channel B format bit picks lane4 MSBs/LSBs
// - Format 1, depth 0: drop two colour LSBs
// - Input mode: dual, single, two single receivers
package bridge_cfg_pkg;

    // ************************************************************
    // Register indices, byte address is four times the index
    // ************************************************************
    localparam logic [5:0] IDX_MODE   = 6'h10;  // Input mode register
    localparam logic [5:0] IDX_BAND_A = 6'h12;  // Channel A clock band
    localparam logic [5:0] IDX_BAND_B = 6'h13;  // Channel B clock band
    localparam logic [5:0] IDX_FMT    = 6'h18;  // Output format control
    localparam logic [5:0] IDX_STAT   = 6'h20;  // Derived link status

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int FMT_DE_INV   = 7;  // Data-enable invert
    localparam int FMT_HS_INV   = 6;  // Hsync invert
    localparam int FMT_VS_INV   = 5;  // Vsync invert
    localparam int FMT_LINK     = 4;  // 1 = single link
    localparam int FMT_A_WIDE   = 3;  // Channel A 24 bpp
    localparam int FMT_B_WIDE   = 2;  // Channel B 24 bpp
    localparam int FMT_A_LOW    = 1;  // Channel A LSBs on lane4
    localparam int FMT_B_LOW    = 0;  // Channel B LSBs on lane4
    localparam int MODE_LSB     = 5;  // Input mode field low bit
    localparam int STAT_DUAL    = 0;  // Dual link active
    localparam int STAT_TWO     = 1;  // Two single links active
    localparam int STAT_B_ON    = 2;  // Output B enabled
    localparam int STAT_A_BAD   = 3;  // Band A code reserved
    localparam int STAT_B_BAD   = 4;  // Band B code reserved
    localparam int STAT_M_BAD   = 5;  // Input mode reserved

    // ************************************************************
    // Reset values and band limits
    // ************************************************************
    localparam logic [7:0] RST_BAND  = 8'h00;
    localparam logic [7:0] RST_FMT   = 8'h70;
    localparam logic [1:0] RST_MODE  = 2'h1;
    localparam logic [7:0] BAND_MIN  = 8'h08;
    localparam logic [7:0] BAND_MAX  = 8'h64;
    localparam logic [10:0] BAND_STEP_MHZ = 11'h005;

    // Input receiver arrangement
    typedef enum logic [1:0] {
        MODE_DUAL   = 2'h0,
        MODE_SINGLE = 2'h1,
        MODE_TWO    = 2'h2,
        MODE_RSVD   = 2'h3
    } in_mode_e;

    // Bus slave states, Gray along idle-ack
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_ACK  = 2'h1
    } bus_state_e;

    // Band code outside the usable span
    function automatic logic band_reserved(input logic [7:0] code);
        band_reserved = (code < BAND_MIN) || (code > BAND_MAX);
    endfunction : band_reserved

    // Lower edge of the band in MHz
    function automatic logic [10:0] band_floor_mhz(input logic [7:0] code);
        band_floor_mhz = 11'({3'h0, code} * BAND_STEP_MHZ);
    endfunction : band_floor_mhz

endpackage : bridge_cfg_pkg

//--- hw/pix_chan_if.sv
`timescale 1ns/1ps
// ****************************************************************
// Pixel channel carrier between register bank and formatter
// ****************************************************************
interface pix_chan_if;
    logic        enable;     // Output channel on
    logic        wide;       // 24 bpp, lane4 on
    logic        low_bits;   // Lane4 carries LSBs
    logic        de_inv;     // Data-enable invert
    logic        hs_inv;     // Hsync invert
    logic        vs_inv;     // Vsync invert
    logic [23:0] pix;        // Incoming RGB, R high
    logic        de;         // Incoming active pixel
    logic        hs;         // Incoming hsync, high in sync
    logic        vs;         // Incoming vsync, high in sync
    logic [17:0] lanes_low;  // Colour bits on lanes 1-3
    logic [5:0]  lane4;      // Two bits per colour
    logic        lane4_en;   // Lane4 driven
    logic        de_out;     // Polarised data-enable
    logic        hs_out;     // Polarised hsync
    logic        vs_out;     // Polarised vsync

    // Register bank side
    modport src (
        output enable, wide, low_bits, de_inv, hs_inv, vs_inv,
        output pix, de, hs, vs,
        input  lanes_low, lane4, lane4_en, de_out, hs_out, vs_out
    );

    // Formatter side
    modport fmt (
        input  enable, wide, low_bits, de_inv, hs_inv, vs_inv,
        input  pix, de, hs, vs,
        output lanes_low, lane4, lane4_en, de_out, hs_out, vs_out
    );
endinterface : pix_chan_if

//--- hw/lvds_chan_formatter.sv
`timescale 1ns/1ps
// ****************************************************************
// One output channel: lane packing and sync polarity
// ****************************************************************
module lvds_chan_formatter (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Channel carrier
    pix_chan_if.fmt   ch
);

    logic [17:0] lanes_ff;     // Lanes 1-3 bits
    logic [17:0] nxt_lanes;
    logic [5:0]  lane4_ff;     // Lane4 bits
    logic [5:0]  nxt_lane4;
    logic        lane4_en_ff;  // Lane4 on
    logic        nxt_lane4_en;
    logic [2:0]  sync_ff;      // de, hs, vs after polarity
    logic [2:0]  nxt_sync;

    // Six kept bits of one colour byte
    function automatic logic [5:0] keep6(input logic [7:0] c, input logic top);
        keep6 = top ? c[7:2] : c[5:0];
    endfunction : keep6

    // Two lane4 bits of one colour byte
    function automatic logic [1:0] pick2(input logic [7:0] c, input logic low);
        pick2 = low ? c[1:0] : c[7:6];
    endfunction : pick2

    // ************************************************************
    // Next lane contents
    // ************************************************************
    always_comb begin
        // Top bits on lanes 1-3 unless lane4 carries the MSBs
        logic top;
        top = !(ch.wide && !ch.low_bits);
        nxt_lanes    = 18'h00000;
        nxt_lane4    = 6'h00;
        nxt_lane4_en = 1'b0;
        nxt_sync     = 3'h0;
        if (ch.enable) begin
            // 18 bpp keeps the six upper bits per colour
            nxt_lanes = {keep6(ch.pix[23:16], top),
                         keep6(ch.pix[15:8], top),
                         keep6(ch.pix[7:0], top)};
            // Lane4 is only driven at 24 bpp
            nxt_lane4_en = ch.wide;
            if (ch.wide) begin
                // MSBs or LSBs of each colour
                nxt_lane4 = {pick2(ch.pix[23:16], ch.low_bits),
                             pick2(ch.pix[15:8], ch.low_bits),
                             pick2(ch.pix[7:0], ch.low_bits)};
            end
            nxt_sync = {ch.de ^ ch.de_inv,
                        ch.hs ^ ch.hs_inv,
                        ch.vs ^ ch.vs_inv};
        end
    end

    // ************************************************************
    // Output registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lanes_ff    <= 18'h00000;
            lane4_ff    <= 6'h00;
            lane4_en_ff <= 1'b0;
            sync_ff     <= 3'h0;
        end else begin
            lanes_ff    <= nxt_lanes;
            lane4_ff    <= nxt_lane4;
            lane4_en_ff <= nxt_lane4_en;
            sync_ff     <= nxt_sync;
        end
    end

    assign ch.lanes_low = lanes_ff;
    assign ch.lane4     = lane4_ff;
    assign ch.lane4_en  = lane4_en_ff;
    assign ch.de_out    = sync_ff[2];
    assign ch.hs_out    = sync_ff[1];
    assign ch.vs_out    = sync_ff[0];

endmodule : lvds_chan_formatter

//--- hw/dsi_lvds_config_regs.sv
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
// ****************************************************************
// Bridge configuration bank with two output formatters
// ****************************************************************
module dsi_lvds_config_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Wishbone classic slave
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Input channel A pixels
    input  wire logic [23:0] in_a_pix,
    input  wire logic        in_a_de,
    input  wire logic        in_a_hs,
    input  wire logic        in_a_vs,
    // Input channel B pixels
    input  wire logic [23:0] in_b_pix,
    input  wire logic        in_b_de,
    input  wire logic        in_b_hs,
    input  wire logic        in_b_vs,
    // Receiver settings
    output logic      [7:0]  input_a_clock_band,
    output logic      [7:0]  input_b_clock_band,
    output logic      [10:0] input_a_band_floor_mhz,
    output logic      [10:0] input_b_band_floor_mhz,
    output logic      [1:0]  input_mode,
    // Link arrangement
    output logic             out_a_enable,
    output logic             out_b_enable,
    output logic             dual_link,
    output logic             two_single_links,
    // Output channel A
    output logic      [17:0] out_a_lanes_low,
    output logic      [5:0]  out_a_lane4_bits,
    output logic             out_a_lane4_en,
    output logic             out_a_de,
    output logic             out_a_hs,
    output logic             out_a_vs,
    // Output channel B
    output logic      [17:0] out_b_lanes_low,
    output logic      [5:0]  out_b_lane4_bits,
    output logic             out_b_lane4_en,
    output logic             out_b_de,
    output logic             out_b_hs,
    output logic             out_b_vs
);

    // ************************************************************
    // Declarations
    // ************************************************************
    bridge_cfg_pkg::bus_state_e bus_ff;      // Slave state
    bridge_cfg_pkg::bus_state_e nxt_bus;
    logic [31:0] rdat_ff;                    // Read data held for ack
    logic [31:0] nxt_rdat;
    logic [7:0]  band_a_ff;                  // Channel A band code
    logic [7:0]  nxt_band_a;
    logic [7:0]  band_b_ff;                  // Channel B band code
    logic [7:0]  nxt_band_b;
    logic [7:0]  fmt_ff;                     // Output format control
    logic [7:0]  nxt_fmt;
    logic [1:0]  mode_ff;                    // Input receiver mode
    logic [1:0]  nxt_mode;
    logic [10:0] floor_a_ff;                 // Band A floor, MHz
    logic [10:0] nxt_floor_a;
    logic [10:0] floor_b_ff;                 // Band B floor, MHz
    logic [10:0] nxt_floor_b;
    logic [3:0]  link_ff;                    // a_on, b_on, dual, two
    logic [3:0]  nxt_link;
    logic [5:0]  idx;                        // Word index of access
    logic        req;                        // Bus request present
    logic        wr_now;                     // Write lands this edge
    logic [7:0]  stat;                       // Derived status byte

    pix_chan_if chan_a ();                   // Carrier to formatter A
    pix_chan_if chan_b ();                   // Carrier to formatter B

    assign idx    = wb_adr_i[7:2];
    assign req    = wb_cyc_i && wb_stb_i;
    // The write lands on the edge that also samples ack
    assign wr_now = req && wb_we_i && wb_sel_i[0] &&
                    (bus_ff == bridge_cfg_pkg::BUS_ACK);

    // ************************************************************
    // Bus slave state: one idle cycle then ack
    // ************************************************************
    always_comb begin
        nxt_bus = bus_ff;
        case (bus_ff)
            bridge_cfg_pkg::BUS_IDLE: begin
                // Take the request, answer next cycle
                if (req) begin
                    nxt_bus = bridge_cfg_pkg::BUS_ACK;
                end
            end
            bridge_cfg_pkg::BUS_ACK: begin
                // Ack lasts one cycle; master must drop stb
                nxt_bus = bridge_cfg_pkg::BUS_IDLE;
            end
            default: begin
                nxt_bus = bridge_cfg_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_ff <= bridge_cfg_pkg::BUS_IDLE;
        end else begin
            bus_ff <= nxt_bus;
        end
    end

    // Ack straight from state, so no extra cycle
    assign wb_ack_o = (bus_ff == bridge_cfg_pkg::BUS_ACK) && req;

    // ************************************************************
    // Read mux, captured in the request cycle
    // ************************************************************
    always_comb begin
        nxt_rdat = rdat_ff;
        if (req && (bus_ff == bridge_cfg_pkg::BUS_IDLE)) begin
            // Unmapped offsets read as zero
            case (idx)
                bridge_cfg_pkg::IDX_MODE: begin
                    nxt_rdat = {24'h000000, 1'b0, mode_ff, 5'h00};
                end
                bridge_cfg_pkg::IDX_BAND_A: begin
                    nxt_rdat = {24'h000000, band_a_ff};
                end
                bridge_cfg_pkg::IDX_BAND_B: begin
                    nxt_rdat = {24'h000000, band_b_ff};
                end
                bridge_cfg_pkg::IDX_FMT: begin
                    nxt_rdat = {24'h000000, fmt_ff};
                end
                bridge_cfg_pkg::IDX_STAT: begin
                    nxt_rdat = {24'h000000, stat};
                end
                default: begin
                    nxt_rdat = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdat_ff <= 32'h00000000;
        end else begin
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_dat_o = rdat_ff;

    // ************************************************************
    // Writable fields
    // ************************************************************
    always_comb begin
        // Every field holds until written or reset
        nxt_band_a = band_a_ff;
        nxt_band_b = band_b_ff;
        nxt_fmt    = fmt_ff;
        nxt_mode   = mode_ff;
        if (wr_now) begin
            case (idx)
                bridge_cfg_pkg::IDX_BAND_A: begin
                    // Reserved codes are stored as written
                    nxt_band_a = wb_dat_i[7:0];
                end
                bridge_cfg_pkg::IDX_BAND_B: begin
                    nxt_band_b = wb_dat_i[7:0];
                end
                bridge_cfg_pkg::IDX_FMT: begin
                    nxt_fmt = wb_dat_i[7:0];
                end
                bridge_cfg_pkg::IDX_MODE: begin
                    nxt_mode = wb_dat_i[bridge_cfg_pkg::MODE_LSB +: 2];
                end
                default: begin
                    // Writes elsewhere are dropped
                    nxt_mode = mode_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            band_a_ff <= bridge_cfg_pkg::RST_BAND;
            band_b_ff <= bridge_cfg_pkg::RST_BAND;
            fmt_ff    <= bridge_cfg_pkg::RST_FMT;
            mode_ff   <= bridge_cfg_pkg::RST_MODE;
        end else begin
            band_a_ff <= nxt_band_a;
            band_b_ff <= nxt_band_b;
            fmt_ff    <= nxt_fmt;
            mode_ff   <= nxt_mode;
        end
    end

    // ************************************************************
    // Band floors and link arrangement
    // ************************************************************
    always_comb begin
        // Floor of band N is 5N MHz, ceiling 5N+5 exclusive
        nxt_floor_a = bridge_cfg_pkg::band_floor_mhz(band_a_ff);
        nxt_floor_b = bridge_cfg_pkg::band_floor_mhz(band_b_ff);
        if (fmt_ff[bridge_cfg_pkg::FMT_LINK]) begin
            // Single link: only output A runs
            nxt_link = 4'b1000;
        end else if (mode_ff == bridge_cfg_pkg::MODE_TWO) begin
            // Each input drives its own output
            nxt_link = 4'b1101;
        end else begin
            // Modes 00, 01 and reserved 11 all give a dual link
            nxt_link = 4'b1110;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            floor_a_ff <= 11'h000;
            floor_b_ff <= 11'h000;
            link_ff    <= 4'b1000;
        end else begin
            floor_a_ff <= nxt_floor_a;
            floor_b_ff <= nxt_floor_b;
            link_ff    <= nxt_link;
        end
    end

    // Status: link state plus codes software must not use
    always_comb begin
        stat = 8'h00;
        stat[bridge_cfg_pkg::STAT_DUAL]  = link_ff[1];
        stat[bridge_cfg_pkg::STAT_TWO]   = link_ff[0];
        stat[bridge_cfg_pkg::STAT_B_ON]  = link_ff[2];
        stat[bridge_cfg_pkg::STAT_A_BAD] = bridge_cfg_pkg::band_reserved(band_a_ff);
        stat[bridge_cfg_pkg::STAT_B_BAD] = bridge_cfg_pkg::band_reserved(band_b_ff);
        stat[bridge_cfg_pkg::STAT_M_BAD] = (mode_ff == bridge_cfg_pkg::MODE_RSVD);
    end

    assign input_a_clock_band     = band_a_ff;
    assign input_b_clock_band     = band_b_ff;
    assign input_a_band_floor_mhz = floor_a_ff;
    assign input_b_band_floor_mhz = floor_b_ff;
    assign input_mode             = mode_ff;
    assign out_a_enable           = link_ff[3];
    assign out_b_enable           = link_ff[2];
    assign dual_link              = link_ff[1];
    assign two_single_links       = link_ff[0];

    // ************************************************************
    // Channel controls and source routing
    // ************************************************************
    // Polarity bits are shared by both outputs
    assign chan_a.enable   = link_ff[3];
    assign chan_a.wide     = fmt_ff[bridge_cfg_pkg::FMT_A_WIDE];
    assign chan_a.low_bits = fmt_ff[bridge_cfg_pkg::FMT_A_LOW];
    assign chan_a.de_inv   = fmt_ff[bridge_cfg_pkg::FMT_DE_INV];
    assign chan_a.hs_inv   = fmt_ff[bridge_cfg_pkg::FMT_HS_INV];
    assign chan_a.vs_inv   = fmt_ff[bridge_cfg_pkg::FMT_VS_INV];
    assign chan_a.pix      = in_a_pix;
    assign chan_a.de       = in_a_de;
    assign chan_a.hs       = in_a_hs;
    assign chan_a.vs       = in_a_vs;

    assign chan_b.enable   = link_ff[2];
    assign chan_b.wide     = fmt_ff[bridge_cfg_pkg::FMT_B_WIDE];
    assign chan_b.low_bits = fmt_ff[bridge_cfg_pkg::FMT_B_LOW];
    assign chan_b.de_inv   = fmt_ff[bridge_cfg_pkg::FMT_DE_INV];
    assign chan_b.hs_inv   = fmt_ff[bridge_cfg_pkg::FMT_HS_INV];
    assign chan_b.vs_inv   = fmt_ff[bridge_cfg_pkg::FMT_VS_INV];
    // A single receiver feeds both halves of a dual link;
    // pixel splitting happens upstream of this block
    assign chan_b.pix = (mode_ff == bridge_cfg_pkg::MODE_SINGLE) ? in_a_pix : in_b_pix;
    assign chan_b.de  = (mode_ff == bridge_cfg_pkg::MODE_SINGLE) ? in_a_de : in_b_de;
    assign chan_b.hs  = (mode_ff == bridge_cfg_pkg::MODE_SINGLE) ? in_a_hs : in_b_hs;
    assign chan_b.vs  = (mode_ff == bridge_cfg_pkg::MODE_SINGLE) ? in_a_vs : in_b_vs;

    // ************************************************************
    // Output formatters
    // ************************************************************
    lvds_chan_formatter fmt_a (
        .clk  (clk),
        .rstn (rstn),
        .ch   (chan_a.fmt)
    );

    lvds_chan_formatter fmt_b (
        .clk  (clk),
        .rstn (rstn),
        .ch   (chan_b.fmt)
    );

    assign out_a_lanes_low  = chan_a.lanes_low;
    assign out_a_lane4_bits = chan_a.lane4;
    assign out_a_lane4_en   = chan_a.lane4_en;
    assign out_a_de         = chan_a.de_out;
    assign out_a_hs         = chan_a.hs_out;
    assign out_a_vs         = chan_a.vs_out;
    assign out_b_lanes_low  = chan_b.lanes_low;
    assign out_b_lane4_bits = chan_b.lane4;
    assign out_b_lane4_en   = chan_b.lane4_en;
    assign out_b_de         = chan_b.de_out;
    assign out_b_hs         = chan_b.hs_out;
    assign out_b_vs         = chan_b.vs_out;

endmodule : dsi_lvds_config_regs

//--- testbench/cfg_regs_properties.sv
`timescale 1ns/1ps
// ****************************************************************
// Bus, band and link checks at the top ports
// ****************************************************************
module cfg_regs_props (
    // Clock, reset and bus answer; grouped to keep the file short
    input wire logic        clk, rstn, wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire logic [7:0]  input_a_clock_band,
    input wire logic [10:0] input_a_band_floor_mhz,
    input wire logic [1:0]  input_mode,
    input wire logic        out_a_enable, out_b_enable, dual_link, two_single_links,
    input wire logic [23:0] in_a_pix,
    input wire logic [17:0] out_a_lanes_low, out_b_lanes_low,
    input wire logic [5:0]  out_a_lane4_bits,
    input wire logic        out_a_lane4_en, out_b_de
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_next_cycle_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("no ack one cycle after request");
    band_floor_a: assert property ($past(rstn) |->
        input_a_band_floor_mhz == 11'($past(input_a_clock_band)) * 11'h005)
        else $error("band floor not five times code");
    out_a_on_a: assert property (out_a_enable)
        else $error("output A disabled");
    out_b_link_a: assert property (out_b_enable == (dual_link || two_single_links))
        else $error("output B enable disagrees with link");
    two_link_mode_a: assert property (two_single_links |-> $past(input_mode) == 2'h2)
        else $error("two links without mode 10");
    dual_link_mode_a: assert property (dual_link |-> $past(input_mode) != 2'h2)
        else $error("dual link with mode 10");
    lane4_quiet_a: assert property (!out_a_lane4_en |-> out_a_lane4_bits == 6'h00)
        else $error("lane4 bits while lane4 off");
    b_off_quiet_a: assert property (!out_b_enable [*3] |->
        out_b_lanes_low == 18'h0 && !out_b_de) else $error("disabled output B not quiet");
    narrow_pack_a: assert property ($past(rstn) && !out_a_lane4_en &&
        !$past(out_a_lane4_en) |-> out_a_lanes_low ==
        {$past(in_a_pix[23:18]), $past(in_a_pix[15:10]), $past(in_a_pix[7:2])})
        else $error("18 bpp packing wrong");
    cover property (two_single_links);
    cover property (dual_link);
    cover property (out_a_lane4_en);
endmodule : cfg_regs_props

bind dsi_lvds_config_regs cfg_regs_props i_cfg_regs_props (.clk, .rstn, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .input_a_clock_band, .input_a_band_floor_mhz, .input_mode, .out_a_enable,
    .out_b_enable, .dual_link, .two_single_links, .in_a_pix, .out_a_lanes_low,
    .out_b_lanes_low, .out_a_lane4_bits, .out_a_lane4_en, .out_b_de);

//--- testbench/dsi_lvds_config_regs_test.sv
`timescale 1ns/1ps
module dsi_lvds_config_regs_test;
    // Stimulus and observed ports
    logic        clk = 0, rstn = 0, we = 0, cyc = 0, stb = 0, ade = 0, ahs = 0, avs = 0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h1;
    logic [31:0] dat = 32'h0, q, wb_dat_o;
    logic [23:0] apix = 24'h0;
    logic [10:0] fa, fb;
    logic [17:0] lanes;
    logic [5:0]  l4, l4b;
    logic        wb_ack_o, out_b_enable, dual_link, two_single_links, l4en, ode, ohs, ovs;
    int          err_total = 0, total_checks = 0;
    always #10 clk = ~clk;
    dsi_lvds_config_regs i_dsi_lvds_config_regs (.clk, .rstn, .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o, .wb_ack_o,
        .in_a_pix(apix), .in_a_de(ade), .in_a_hs(ahs), .in_a_vs(avs), .in_b_pix(apix),
        .in_b_de(1'b0), .in_b_hs(1'b0), .in_b_vs(1'b0), .input_a_clock_band(),
        .input_b_clock_band(), .input_a_band_floor_mhz(fa), .input_b_band_floor_mhz(fb),
        .input_mode(), .out_a_enable(), .out_b_enable, .dual_link, .two_single_links,
        .out_a_lanes_low(lanes), .out_a_lane4_bits(l4), .out_a_lane4_en(l4en), .out_a_de(ode),
        .out_a_hs(ohs), .out_a_vs(ovs), .out_b_lanes_low(), .out_b_lane4_bits(l4b),
        .out_b_lane4_en(), .out_b_de(), .out_b_hs(), .out_b_vs());
    // One comparison, four-state exact
    task chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("ERROR t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Classic single cycle; the watchdog bounds the wait for ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'h3, w, a, 24'h0, d};
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {cyc, stb} <= 2'h0;
    endtask : bus
    task t_reset;
        bus(0, 8'h48, 8'h00);
        chk(q, 32'h00);
        bus(0, 8'h60, 8'h00);
        chk(q, 32'h70);
        bus(0, 8'h40, 8'h00);
        chk(q, 32'h20);
        bus(0, 8'h80, 8'h00);
        chk(q, 32'h18);
        $display("reset values done");
    endtask : t_reset
    task t_band;
        bus(1, 8'h48, 8'h08);
        bus(1, 8'h4C, 8'h64);
        bus(1, 8'h84, 8'hFF);
        bus(0, 8'h48, 8'h00);
        chk(q, 32'h08);
        sel <= 4'h0;
        bus(1, 8'h48, 8'h10);
        sel <= 4'h1;
        bus(0, 8'h48, 8'h00);
        chk(q, 32'h08);
        bus(0, 8'h4C, 8'h00);
        chk(q, 32'h64);
        chk(fa, 32'h28);
        chk(fb, 32'h1F4);
        bus(0, 8'h84, 8'h00);
        chk(q, 32'h00);
        bus(0, 8'h80, 8'h00);
        chk(q, 32'h00);
        $display("clock bands done");
    endtask : t_band
    task t_pol;
        for (int i = 0; i < 2; i++) begin
            bus(1, 8'h60, {{3{i[0]}}, 5'h10});
            {ade, ahs, avs} <= 3'h6;
            repeat (3) @(posedge clk);
            chk(ode, !i[0]);
            chk(ohs, !i[0]);
            chk(ovs, i[0]);
        end
        $display("polarity done");
    endtask : t_pol
    task t_link;
        for (int m = 0; m < 4; m++) begin
            bus(1, 8'h40, {1'b0, m[1:0], 5'h00});
            bus(1, 8'h60, 8'h00);
            repeat (2) @(posedge clk);
            chk(dual_link, m != 2);
            chk(two_single_links, m == 2);
            chk(out_b_enable, 1);
        end
        bus(1, 8'h60, 8'h10);
        repeat (2) @(posedge clk);
        chk(out_b_enable, 0);
        $display("link arrangement done");
    endtask : t_link
    task t_lanes;
        apix <= 24'hC3A55A;
        for (int k = 0; k < 4; k++) begin
            bus(1, 8'h60, {4'h0, {2{k[1]}}, {2{k[0]}}});
            repeat (3) @(posedge clk);
            chk(l4en, k[1]);
            chk(lanes, k == 2 ? 18'h0395A : 18'h30A56);
            chk(l4, k < 2 ? 6'h00 : (k == 2 ? 6'h39 : 6'h36));
            chk(l4b, k < 2 ? 6'h00 : (k == 2 ? 6'h39 : 6'h36));
        end
        $display("lane packing done");
    endtask : t_lanes
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1;
        t_reset;
        t_band;
        t_pol;
        t_link;
        t_lanes;
        end_sim;
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        end_sim;
    end
endmodule : dsi_lvds_config_regs_test
